// ---- verilog/lpb_consts.vh ----
// Constants of the parallel LCD bus master: register map, fields, resets.
// Included by the bus master and its bench; holds definitions only.
`ifndef LPB_CONSTS_VH
`define LPB_CONSTS_VH

// Byte addresses of the word registers on the AHB-Lite slave.
`define LPB_ADDR_BUS_STATUS 8'h00
`define LPB_ADDR_READ_LOW_BYTE 8'h04
`define LPB_ADDR_READ_HIGH_BYTE 8'h08
`define LPB_ADDR_FIFO_PUSH 8'h0c
`define LPB_ADDR_BUS_CONFIG 8'h10
`define LPB_ADDR_BITS 8

// Status fields.
`define LPB_STAT_ROOM_BIT 0
`define LPB_STAT_VALID_BIT 1

// Command byte fields.
`define LPB_CMD_DC_BIT 0
`define LPB_CMD_READ_BIT 1

// Configuration fields and reset values.
`define LPB_CFG_LOW_LSB 0
`define LPB_CFG_HIGH_LSB 8
`define LPB_CFG_WIDE_BIT 16
`define LPB_READ_LOW_RESET 8'h02
`define LPB_READ_HIGH_RESET 8'h01

// Strobe timing in component clock periods, and the room-flag threshold in bytes.
`define LPB_READ_LOW_MIN 8'h02
`define LPB_READ_HIGH_MIN 8'h01
`define LPB_WRITE_HIGH_HOLD 8'h02
`define LPB_ROOM_BYTES 2

// AHB transfer type code for a non-sequential transfer.
`define LPB_HTRANS_NONSEQ 2'h2

`endif

// ---- verilog/lpb_sync2.v ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes the group is only sampled while it is known to be stable.
`timescale 1ns/10ps
module lpb_sync2 #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_q;

  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage1_q <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_q <= pinIn;
      syncOut <= stage1_q;
    end
  end
endmodule // lpb_sync2

// ---- verilog/lpb_byte_fifo.v ----
// Shared command/data FIFO in flip-flops, with valid/ready on both sides.
// Assumes one clock; the fill count is exported for the room flag.
`timescale 1ns/10ps
module lpb_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire rst_n,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  output reg [AW:0] fillCount
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  wire doPush;
  wire doPop;

  assign inReady = (fillCount != DEPTH[AW:0]);
  assign outValid = (fillCount != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_q];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always @(posedge mclk)
  begin
    if (doPush)
      mem[wrPtr_q] <= inData;
  end

  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      fillCount <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doPush)
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      if (doPop)
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      if (doPush && !doPop)
        fillCount <= fillCount + 1'b1;
      else if (doPop && !doPush)
        fillCount <= fillCount - 1'b1;
    end
  end
endmodule // lpb_byte_fifo

// ---- verilog/lpb_bus_master.v ----
// Parallel LCD bus master: AHB-Lite register slave, command/data FIFO and
// strobe sequencer for an 8- or 16-bit parallel bus to an LCD controller.
// Assumes a single AHB master and input lanes asynchronous to mclk.
`timescale 1ns/10ps
`include "lpb_consts.vh"
module lpb_bus_master #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire mclk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [7:0] inputLowLane,
  input wire [7:0] inputHighLane,
  output reg chipSelN,
  output reg writeStrobeN,
  output reg readStrobeN,
  output reg dataCmdSel,
  output reg [7:0] outputLowLane,
  output reg [7:0] outputHighLane,
  output reg outputDriveEn
);
  localparam [8:0] ST_IDLE = 9'h001, ST_DLOW = 9'h002, ST_DHIGH = 9'h004;
  localparam [8:0] ST_WSET = 9'h008, ST_WLOW = 9'h010, ST_WHOLD = 9'h020;
  localparam [8:0] ST_RSET = 9'h040, ST_RLOW = 9'h080, ST_RHIGH = 9'h100;

  // Bus slave state.
  reg dataPhase_q, phaseWrite_q;
  reg [`LPB_ADDR_BITS-1:0] phaseAddr_q;

  // Software-visible state.
  reg [7:0] readLowCount_q, readHighCount_q, readLowByte_q, readHighByte_q;
  reg wideBus_q, dataValid_q;

  // Sequencer state.
  reg [8:0] state_q;
  reg [7:0] count_q, cmd_q, wrLow_q;
  reg captureDue_q;

  wire [7:0] syncLow, syncHigh, fifoOutData, statusByte;
  wire fifoInReady, fifoOutValid, fifoOutReady, fifoPush, roomFlag;
  wire captureNow, statusRead, lowRead, highRead;
  wire [FIFO_AW:0] fifoFill;

  // Clamp a software count to the smallest legal strobe width.
  function [7:0] clampMin;
    input [7:0] value;
    input [7:0] floor;
    clampMin = (value < floor) ? floor : value;
  endfunction

  lpb_sync2 #(
    .WIDTH(16)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn({inputHighLane, inputLowLane}),
    .syncOut({syncHigh, syncLow})
  );

  lpb_byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(hwdata[7:0]),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData),
    .fillCount(fifoFill)
  );

  assign fifoOutReady = (state_q == ST_IDLE) || (state_q == ST_DLOW) || (state_q == ST_DHIGH);
  assign fifoPush = dataPhase_q && phaseWrite_q &&
    (phaseAddr_q == `LPB_ADDR_FIFO_PUSH);
  assign roomFlag = ((FIFO_DEPTH[FIFO_AW:0] - fifoFill) >= `LPB_ROOM_BYTES);
  assign statusByte = {6'h00, dataValid_q, roomFlag};
  assign captureNow = (state_q == ST_RHIGH) && captureDue_q;
  assign statusRead = dataPhase_q && !phaseWrite_q &&
    (phaseAddr_q == `LPB_ADDR_BUS_STATUS);
  assign lowRead = dataPhase_q && !phaseWrite_q &&
    (phaseAddr_q == `LPB_ADDR_READ_LOW_BYTE);
  assign highRead = dataPhase_q && !phaseWrite_q &&
    (phaseAddr_q == `LPB_ADDR_READ_HIGH_BYTE);

  // AHB-Lite slave: one wait state per transfer, FIFO writes stall when full.
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dataPhase_q <= 1'b0;
      phaseWrite_q <= 1'b0;
      phaseAddr_q <= {`LPB_ADDR_BITS{1'b0}};
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      readLowCount_q <= `LPB_READ_LOW_RESET;
      readHighCount_q <= `LPB_READ_HIGH_RESET;
      wideBus_q <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      if (!dataPhase_q)
      begin
        if (hsel && hready && (htrans == `LPB_HTRANS_NONSEQ))
        begin
          dataPhase_q <= 1'b1;
          phaseWrite_q <= hwrite;
          phaseAddr_q <= {haddr[`LPB_ADDR_BITS-1:2], 2'b00};
          hreadyout <= 1'b0;
        end
      end
      else if (phaseWrite_q)
      begin
        if (phaseAddr_q == `LPB_ADDR_BUS_CONFIG)
        begin
          readLowCount_q <= clampMin(hwdata[`LPB_CFG_LOW_LSB +: 8],
            `LPB_READ_LOW_MIN);
          readHighCount_q <= clampMin(hwdata[`LPB_CFG_HIGH_LSB +: 8],
            `LPB_READ_HIGH_MIN);
          wideBus_q <= hwdata[`LPB_CFG_WIDE_BIT];
        end
        if (!fifoPush || fifoInReady)
        begin
          dataPhase_q <= 1'b0;
          hreadyout <= 1'b1;
        end
      end
      else
      begin
        dataPhase_q <= 1'b0;
        hreadyout <= 1'b1;
        case (phaseAddr_q)
          `LPB_ADDR_BUS_STATUS:
            hrdata <= {24'h000000, statusByte};
          `LPB_ADDR_READ_LOW_BYTE:
            hrdata <= {24'h000000, readLowByte_q};
          `LPB_ADDR_READ_HIGH_BYTE:
            hrdata <= {24'h000000, readHighByte_q};
          `LPB_ADDR_BUS_CONFIG:
            hrdata <= {15'h0000, wideBus_q, readHighCount_q, readLowCount_q};
          default:
            hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Read-clear registers; a capture in the same cycle wins over the clear.
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dataValid_q <= 1'b0;
      readLowByte_q <= 8'h00;
      readHighByte_q <= 8'h00;
    end
    else
    begin
      if (captureNow)
      begin
        dataValid_q <= 1'b1;
        readLowByte_q <= syncLow;
        readHighByte_q <= wideBus_q ? syncHigh : 8'h00;
      end
      else
      begin
        if (statusRead)
          dataValid_q <= 1'b0;
        if (lowRead)
          readLowByte_q <= 8'h00;
        if (highRead)
          readHighByte_q <= 8'h00;
      end
    end
  end

  // Strobe sequencer.
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      count_q <= 8'h00;
      cmd_q <= 8'h00;
      wrLow_q <= 8'h00;
      captureDue_q <= 1'b0;
      chipSelN <= 1'b1;
      writeStrobeN <= 1'b1;
      readStrobeN <= 1'b1;
      dataCmdSel <= 1'b0;
      outputLowLane <= 8'h00;
      outputHighLane <= 8'h00;
      outputDriveEn <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          chipSelN <= 1'b1;
          writeStrobeN <= 1'b1;
          readStrobeN <= 1'b1;
          outputDriveEn <= 1'b0;
          if (fifoOutValid)
          begin
            cmd_q <= fifoOutData;
            if (fifoOutData[`LPB_CMD_READ_BIT])
            begin
              state_q <= ST_RSET;
              chipSelN <= 1'b0;
              dataCmdSel <= fifoOutData[`LPB_CMD_DC_BIT];
            end
            else
              state_q <= ST_DLOW;
          end
        end
        ST_DLOW:
        begin
          if (fifoOutValid)
          begin
            wrLow_q <= fifoOutData;
            if (wideBus_q)
              state_q <= ST_DHIGH;
            else
            begin
              state_q <= ST_WSET;
              chipSelN <= 1'b0;
              dataCmdSel <= cmd_q[`LPB_CMD_DC_BIT];
              outputLowLane <= fifoOutData;
              outputDriveEn <= 1'b1;
            end
          end
        end
        ST_DHIGH:
        begin
          if (fifoOutValid)
          begin
            state_q <= ST_WSET;
            chipSelN <= 1'b0;
            dataCmdSel <= cmd_q[`LPB_CMD_DC_BIT];
            outputLowLane <= wrLow_q;
            outputHighLane <= fifoOutData;
            outputDriveEn <= 1'b1;
          end
        end
        ST_WSET:
        begin
          state_q <= ST_WLOW;
          writeStrobeN <= 1'b0;
        end
        ST_WLOW:
        begin
          writeStrobeN <= 1'b1;
          chipSelN <= 1'b1;
          state_q <= ST_WHOLD;
          count_q <= `LPB_WRITE_HIGH_HOLD - 8'h01;
        end
        ST_WHOLD:
        begin
          if (count_q == 8'h00)
          begin
            state_q <= ST_IDLE;
            outputDriveEn <= 1'b0;
          end
          else
            count_q <= count_q - 8'h01;
        end
        ST_RSET:
        begin
          state_q <= ST_RLOW;
          readStrobeN <= 1'b0;
          count_q <= readLowCount_q - 8'h01;
        end
        ST_RLOW:
        begin
          if (count_q == 8'h00)
          begin
            state_q <= ST_RHIGH;
            readStrobeN <= 1'b1;
            chipSelN <= 1'b1;
            count_q <= readHighCount_q - 8'h01;
            captureDue_q <= 1'b1;
          end
          else
            count_q <= count_q - 8'h01;
        end
        ST_RHIGH:
        begin
          captureDue_q <= 1'b0;
          if (count_q == 8'h00)
            state_q <= ST_IDLE;
          else
            count_q <= count_q - 8'h01;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // lpb_bus_master

// ---- verification/lpb_bus_master_assertions.sv ----
// Pin timing checker of the parallel LCD bus master.
// Sees only top-level ports; bound to the master below its endmodule.
`timescale 1ns/10ps
module lpb_bus_master_assertions (
  input wire mclk,
  input wire rst_n,
  input wire chipSelN,
  input wire writeStrobeN,
  input wire readStrobeN,
  input wire dataCmdSel,
  input wire [7:0] outputLowLane,
  input wire [7:0] outputHighLane,
  input wire outputDriveEn
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_wr_low; $fell(writeStrobeN) |=> writeStrobeN; endproperty
  a_wr_low: assert property (p_wr_low) else $error("write strobe low too long");
  property p_wr_high; $rose(writeStrobeN) |-> writeStrobeN [*3]; endproperty
  a_wr_high: assert property (p_wr_high) else $error("write strobe high too short");
  property p_sel_setup;
    $fell(writeStrobeN) || $fell(readStrobeN) |-> $stable(dataCmdSel) && $past(!chipSelN);
  endproperty
  a_sel_setup: assert property (p_sel_setup) else $error("select not set up");
  property p_sel_hold;
    $rose(writeStrobeN) && outputDriveEn |=> $stable(dataCmdSel) [*2];
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select not held");
  property p_dat_setup;
    $fell(writeStrobeN) |-> outputDriveEn && $stable({outputHighLane, outputLowLane});
  endproperty
  a_dat_setup: assert property (p_dat_setup) else $error("write data not set up");
  property p_dat_hold;
    $rose(writeStrobeN) |=> outputDriveEn && $stable({outputHighLane, outputLowLane});
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("write data not held");
  property p_idle; chipSelN |-> writeStrobeN && readStrobeN; endproperty
  a_idle: assert property (p_idle) else $error("strobe active while deselected");
  property p_rd_low; $fell(readStrobeN) |=> !readStrobeN; endproperty
  a_rd_low: assert property (p_rd_low) else $error("read strobe low too short");
  property p_rd_high; $rose(readStrobeN) |=> readStrobeN; endproperty
  a_rd_high: assert property (p_rd_high) else $error("read strobe high too short");
  property p_rd_end; $rose(readStrobeN) |-> $rose(chipSelN) && !outputDriveEn; endproperty
  a_rd_end: assert property (p_rd_end) else $error("read end misaligned");
endmodule // lpb_bus_master_assertions

bind lpb_bus_master lpb_bus_master_assertions u_lpb_bus_master_assertions (.mclk(mclk),
  .rst_n(rst_n), .chipSelN(chipSelN), .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
  .dataCmdSel(dataCmdSel), .outputLowLane(outputLowLane), .outputHighLane(outputHighLane),
  .outputDriveEn(outputDriveEn));

// ---- verification/lpb_lcd_model.sv ----
// Behavioural LCD controller answering reads on the parallel bus.
// Assumes strobes change on mclk; the lanes have no pull resistors.
`timescale 1ns/10ps
module lpb_lcd_model (
  input wire mclk,
  input wire chipSelN,
  input wire readStrobeN,
  input wire [15:0] readValue,
  input wire [1:0] accessDelay,
  output wire [7:0] inputLowLane,
  output wire [7:0] inputHighLane
);
  logic [1:0] lowCountQ = 2'h0;
  logic [15:0] lastQ = 16'h0000;
  wire driving = !readStrobeN && !chipSelN && lowCountQ >= accessDelay;
  always @(posedge mclk)
  begin
    lowCountQ <= readStrobeN ? 2'h0 : (lowCountQ == 2'h3 ? 2'h3 : lowCountQ + 2'h1);
    if (driving)
      lastQ <= readValue;
  end
  // no hold after the strobe rises.
  assign {inputHighLane, inputLowLane} = driving ? readValue : ~lastQ;
endmodule // lpb_lcd_model

// ---- verification/lpb_bus_master_tb.sv ----
// Self-checking bench of the parallel LCD bus master.
// Drives the AHB-Lite port as sole master; an LCD model answers reads.
`timescale 1ns/10ps
`include "lpb_consts.vh"
module lpb_bus_master_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rdv, r;
  logic hreadyout, hresp, chipSelN, writeStrobeN, readStrobeN, dataCmdSel, outputDriveEn;
  logic [7:0] inputLowLane, inputHighLane, outputLowLane, outputHighLane, lowCnt, highCnt;
  logic [15:0] readValue = 16'h0000;
  logic [1:0] accessDelay = 2'h0;
  logic [16:0] laneMask = 17'h1ffff;
  logic [16:0] expQ[$];
  logic [31:0] seed = 32'd55655;
  logic wide = 1'b0;
  int failures = 0;
  int totalChecks = 0;
  int n;
  int rdLowRun = 0;
  logic rdDc = 1'b0;

  initial forever #4 mclk = ~mclk;

  lpb_bus_master u_lpb_bus_master (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .inputLowLane(inputLowLane),
    .inputHighLane(inputHighLane), .chipSelN(chipSelN), .writeStrobeN(writeStrobeN),
    .readStrobeN(readStrobeN), .dataCmdSel(dataCmdSel), .outputLowLane(outputLowLane),
    .outputHighLane(outputHighLane), .outputDriveEn(outputDriveEn));
  lpb_lcd_model u_lpb_lcd_model (.mclk(mclk), .chipSelN(chipSelN), .readStrobeN(readStrobeN),
    .readValue(readValue), .accessDelay(accessDelay), .inputLowLane(inputLowLane),
    .inputHighLane(inputHighLane));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [31:0] stat(input logic room, input logic valid);
    return {30'h0, valid, room};
  endfunction

  task close_out;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits for the slave's ready; a stuck bus ends the run.
  task waitReady;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 1500)
      begin
        failures++;
        close_out;
      end
      @(posedge mclk);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= `LPB_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    waitReady;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    waitReady;
    rdv = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task rdChk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdv & mask, exp);
  endtask

  task pushWrite(input logic dc, input logic [15:0] v, input logic probe);
    expQ.push_back({dc, v});
    bus(1'b1, `LPB_ADDR_FIFO_PUSH, {30'h0, 1'b0, dc});
    if (probe)
      rdChk(`LPB_ADDR_BUS_STATUS, 32'hffffffff, stat(1'b0, 1'b0));
    bus(1'b1, `LPB_ADDR_FIFO_PUSH, {24'h0, v[7:0]});
    if (wide)
      bus(1'b1, `LPB_ADDR_FIFO_PUSH, {24'h0, v[15:8]});
  endtask

  always @(posedge mclk)
    if (rst_n && writeStrobeN === 1'b0)
    begin
      check({15'h0, laneMask & {dataCmdSel, outputHighLane, outputLowLane}},
        {15'h0, laneMask & expQ.pop_front()});
    end

  // Read strobe low width and the select value of each read.
  always @(posedge mclk)
    if (rst_n)
    begin
      rdLowRun <= (readStrobeN === 1'b0) ? rdLowRun + 1 : 0;
      if (readStrobeN === 1'b1 && rdLowRun != 0)
        check(rdLowRun, {24'h0, lowCnt});
      if (readStrobeN === 1'b0)
        check({31'h0, dataCmdSel}, {31'h0, rdDc});
    end

  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdChk(`LPB_ADDR_BUS_STATUS, 32'hffffffff, stat(1'b1, 1'b0));
    rdChk(8'h3c, 32'hffffffff, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      r = rnd();
      wide = m[0];
      lowCnt = (m == 0) ? 8'h02 : (m == 3) ? 8'hff : 8'h02 + r[7:0] % 8'h06;
      highCnt = (m == 0) ? 8'h01 : (m == 3) ? 8'hff : 8'h01 + {6'h0, r[9:8]};
      laneMask <= wide ? 17'h1ffff : 17'h100ff;
      accessDelay <= (lowCnt > 8'h05) ? 2'h3 : lowCnt[1:0] - 2'h2;
      readValue <= r[31:16];
      bus(1'b1, `LPB_ADDR_BUS_CONFIG, {15'h0, wide, highCnt, lowCnt});
      rdDc = r[10];
      bus(1'b1, `LPB_ADDR_FIFO_PUSH, {30'h0, 1'b1, rdDc});
      pushWrite(r[11], rnd(), 1'b0);
      pushWrite(r[12], rnd(), 1'b0);
      if (m == 3)
      begin
        rdChk(`LPB_ADDR_BUS_STATUS, 32'hffffffff, stat(1'b1, 1'b0));
        pushWrite(r[13], rnd(), 1'b1);
      end
      rdv = 32'h0;
      for (int k = 0; k < 600 && rdv[1] !== 1'b1; k++)
        bus(1'b0, `LPB_ADDR_BUS_STATUS, 32'h0);
      check(rdv & 32'h2, 32'h2);
      if (rdv[1] !== 1'b1)
        close_out;
      rdChk(`LPB_ADDR_BUS_STATUS, 32'h2, 32'h0);
      rdChk(`LPB_ADDR_READ_LOW_BYTE, 32'hffffffff, {24'h0, readValue[7:0]});
      rdChk(`LPB_ADDR_READ_HIGH_BYTE, 32'hffffffff, {24'h0, wide ? readValue[15:8] : 8'h0});
      rdChk(`LPB_ADDR_READ_LOW_BYTE, 32'hffffffff, 32'h0);
      rdChk(`LPB_ADDR_READ_HIGH_BYTE, 32'hffffffff, 32'h0);
      for (int k = 0; k < 3000 && expQ.size() != 0; k++)
        @(posedge mclk);
      check(expQ.size(), 32'h0);
      repeat (4) @(posedge mclk);
    end
    rdChk(`LPB_ADDR_BUS_STATUS, 32'hffffffff, stat(1'b1, 1'b0));
    close_out;
  end
endmodule // lpb_bus_master_tb
